/* File: hdl/bus_ctrl_defs.vh */
// Purpose: constants for the bus control register block
// Assumes: 32-bit axi4-lite register bus, 20 MHz clock
// Notes: offsets are byte addresses
`ifndef BUS_CTRL_DEFS_VH
`define BUS_CTRL_DEFS_VH
`define OFS_BUS_CONTROL_ONE 4'h0
`define OFS_BUS_STATUS 4'h4
`define BIT_DMA_BURST_PRIORITY 16
`define BIT_ADDR_FLOAT 15
`define BIT_STROBE_FLOAT 14
`define POS_AREA0_BURST 11
`define POS_AREA5_BURST 8
`define POS_AREA6_BURST 5
`define BIT_MUXED_IF 17
`define BIT_PCCARD_IF 0
`define BUS_CONTROL_ONE_WRITE_MASK 32'h0003ffe1
`define BUS_CONTROL_ONE_RESET 32'h00000000
`define BURST_SRAM 3'h0
`define BURST_4 3'h1
`define BURST_8 3'h2
`define BURST_16 3'h3
`define BURST_32 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define GRANT_NONE 4'h0
`define GRANT_RELEASE 4'h1
`define GRANT_REFRESH 4'h2
`define GRANT_DMA 4'h4
`define GRANT_CPU 4'h8
`endif

/* File: hdl/burst_decode.v */
// Purpose: decode one area burst field into access style and burst length
// Assumes: field and muxed flag come from registers on the same clock
// Notes: reserved codes and muxed areas fall back to plain access
`timescale 1ns/1ps
`include "bus_ctrl_defs.vh"
module burst_decode (
   input wire [2:0] i_sel,
   input wire i_muxed,
   output reg o_burst,
   output reg [5:0] o_len,
   output reg o_reserved
);
   always @* begin
      o_burst = 1'b0;
      o_len = 6'h01;
      o_reserved = 1'b0;
      if (!i_muxed) begin
         case (i_sel)
            `BURST_SRAM: o_len = 6'h01;
            `BURST_4: begin
               o_burst = 1'b1;
               o_len = 6'h04;
            end
            `BURST_8: begin
               o_burst = 1'b1;
               o_len = 6'h08;
            end
            `BURST_16: begin
               o_burst = 1'b1;
               o_len = 6'h10;
            end
            `BURST_32: begin
               o_burst = 1'b1;
               o_len = 6'h20;
            end
            default: o_reserved = 1'b1;
         endcase
      end
   end
endmodule // burst_decode

/* File: hdl/pin_sync.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous input level
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
   input wire i_clk,
   input wire i_nrst,
   input wire i_pin,
   output reg o_level
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule // pin_sync

/* File: hdl/bus_ctrl_burst_hiz_cfg.v */
// Purpose: bus control register one: dma burst priority, pin float control,
//          area 0/5/6 burst selection, bus arbitration and pin enables
// Assumes: axi4-lite slave, 20 MHz clock, power-on reset on i_nrst
// Notes: output enables are active low (low = pin driven)
`timescale 1ns/1ps
`include "bus_ctrl_defs.vh"
module bus_ctrl_burst_hiz_cfg (
   input wire i_clk,
   input wire i_nrst,
   input wire [3:0] i_awaddr,
   input wire i_awvalid,
   output reg o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [3:0] i_araddr,
   input wire i_arvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   input wire i_area0_muxed,
   input wire i_standby,
   input wire i_ext_bus_req,
   input wire i_refresh_req,
   input wire i_dma_req,
   input wire i_dma_burst_active,
   input wire i_cpu_req,
   output reg [3:0] o_grant,
   output reg o_bus_released,
   output reg o_addr_group_oe_n,
   output reg o_strobe_group_oe_n,
   output reg o_area0_burst,
   output reg [5:0] o_area0_len,
   output reg o_area5_burst,
   output reg [5:0] o_area5_len,
   output reg o_area6_burst,
   output reg [5:0] o_area6_len
);
   // ***********************************************
   // register
   // ***********************************************
   reg [31:0] bus_control_one;
   wire dma_burst_priority = bus_control_one[`BIT_DMA_BURST_PRIORITY];
   wire addr_group_float_ctl = bus_control_one[`BIT_ADDR_FLOAT];
   wire strobe_group_float_ctl = bus_control_one[`BIT_STROBE_FLOAT];
   wire [2:0] area0_burst_sel = bus_control_one[`POS_AREA0_BURST+2:`POS_AREA0_BURST];
   wire [2:0] area5_burst_sel = bus_control_one[`POS_AREA5_BURST+2:`POS_AREA5_BURST];
   wire [2:0] area6_burst_sel = bus_control_one[`POS_AREA6_BURST+2:`POS_AREA6_BURST];
   wire muxed_addr_data_if = bus_control_one[`BIT_MUXED_IF];
   wire pccard_if = bus_control_one[`BIT_PCCARD_IF];
   wire standby_sync;
   // standby comes from another domain, so it is filtered first
   pin_sync u_standby_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_pin(i_standby),
      .o_level(standby_sync)
   );
   // ***********************************************
   // axi4-lite write channel
   // ***********************************************
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire aw_take = i_awvalid && o_awready;
   wire w_take = i_wvalid && o_wready;
   wire have_aw = aw_held || aw_take;
   wire have_w = w_held || w_take;
   wire [3:0] wr_addr = aw_held ? aw_addr : i_awaddr;
   wire [31:0] wr_data = w_held ? w_data : i_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : i_wstrb;
   // aw and w may arrive in either order; each is held until both are in
   // a new write waits for the previous response to be taken
   wire do_write = have_aw && have_w && !o_bvalid;
   reg [31:0] byte_mask;
   reg [31:0] next_bus_control_one;
   integer k;
   // only writable bits under enabled byte lanes change
   always @* begin
      byte_mask = 32'h00000000;
      for (k = 0; k < 4; k = k + 1) begin
         byte_mask[k*8 +: 8] = {8{wr_strb[k]}};
      end
      next_bus_control_one = (bus_control_one & ~(byte_mask & `BUS_CONTROL_ONE_WRITE_MASK)) |
         (wr_data & byte_mask & `BUS_CONTROL_ONE_WRITE_MASK);
   end
   // ***********************************************
   // write address decode
   // ***********************************************
   reg wr_hits_ctrl;
   reg [1:0] next_bresp;
   always @* begin
      wr_hits_ctrl = 1'b0;
      next_bresp = `RESP_OKAY;
      if (wr_addr == `OFS_BUS_CONTROL_ONE) begin
         wr_hits_ctrl = 1'b1;
      end else if (wr_addr == `OFS_BUS_STATUS) begin
         // status is read only; writes are accepted and dropped
         next_bresp = `RESP_OKAY;
      end else begin
         next_bresp = `RESP_SLVERR;
      end
   end
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bus_control_one <= `BUS_CONTROL_ONE_RESET;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= `RESP_OKAY;
      end else begin
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= next_bresp;
            if (wr_hits_ctrl) begin
               bus_control_one <= next_bus_control_one;
            end
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               aw_addr <= i_awaddr;
               o_awready <= 1'b0;
            end
            if (w_take) begin
               w_held <= 1'b1;
               w_data <= i_wdata;
               w_strb <= i_wstrb;
               o_wready <= 1'b0;
            end
         end
      end
   end
   // ***********************************************
   // axi4-lite read channel
   // ***********************************************
   // status word: released, standby, grant, len-32 flags, area 0 muxed
   wire [31:0] status_word = {22'h000000, o_bus_released, standby_sync, o_grant, o_area6_len[5],
      o_area5_len[5], o_area0_len[5], i_area0_muxed};
   reg [31:0] next_rdata;
   reg [1:0] next_rresp;
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `RESP_OKAY;
      if (i_araddr == `OFS_BUS_CONTROL_ONE) begin
         next_rdata = bus_control_one;
      end else if (i_araddr == `OFS_BUS_STATUS) begin
         next_rdata = status_word;
      end else begin
         next_rresp = `RESP_SLVERR;
      end
   end
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `RESP_OKAY;
      end else begin
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= next_rdata;
            o_rresp <= next_rresp;
         end
      end
   end
   // ***********************************************
   // burst selection per area
   // ***********************************************
   wire a0_burst;
   wire a5_burst;
   wire a6_burst;
   wire [5:0] a0_len;
   wire [5:0] a5_len;
   wire [5:0] a6_len;
   // pc-card selection overrides the muxed setting for areas 5 and 6
   wire area56_muxed = muxed_addr_data_if && !pccard_if;
   burst_decode u_area0 (
      .i_sel(area0_burst_sel),
      .i_muxed(i_area0_muxed),
      .o_burst(a0_burst),
      .o_len(a0_len),
      .o_reserved()
   );
   burst_decode u_area5 (
      .i_sel(area5_burst_sel),
      .i_muxed(area56_muxed),
      .o_burst(a5_burst),
      .o_len(a5_len),
      .o_reserved()
   );
   burst_decode u_area6 (
      .i_sel(area6_burst_sel),
      .i_muxed(area56_muxed),
      .o_burst(a6_burst),
      .o_len(a6_len),
      .o_reserved()
   );
   // ***********************************************
   // arbitration and pin float control
   // ***********************************************
   reg [3:0] next_grant;
   always @* begin
      next_grant = `GRANT_NONE;
      // with priority on and a burst under way, release and refresh wait
      if (dma_burst_priority && i_dma_burst_active) begin
         if (i_dma_req) begin
            next_grant = `GRANT_DMA;
         end else if (i_cpu_req) begin
            next_grant = `GRANT_CPU;
         end
      end else if (i_ext_bus_req) begin
         next_grant = `GRANT_RELEASE;
      end else if (i_refresh_req) begin
         next_grant = `GRANT_REFRESH;
      end else if (i_dma_req) begin
         next_grant = `GRANT_DMA;
      end else if (i_cpu_req) begin
         next_grant = `GRANT_CPU;
      end
   end
   wire next_released = (next_grant == `GRANT_RELEASE);
   // ***********************************************
   // pin float decisions
   // ***********************************************
   // address group floats on release regardless of its control bit
   wire next_addr_oe_n = next_released || (standby_sync && !addr_group_float_ctl);
   // strobe group is held driven in both cases when its control bit is set
   wire next_strobe_oe_n = !strobe_group_float_ctl && (next_released || standby_sync);
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_grant <= `GRANT_NONE;
         o_bus_released <= 1'b0;
         o_addr_group_oe_n <= 1'b0;
         o_strobe_group_oe_n <= 1'b0;
         o_area0_burst <= 1'b0;
         o_area0_len <= 6'h01;
         o_area5_burst <= 1'b0;
         o_area5_len <= 6'h01;
         o_area6_burst <= 1'b0;
         o_area6_len <= 6'h01;
      end else begin
         o_grant <= next_grant;
         o_bus_released <= next_released;
         o_addr_group_oe_n <= next_addr_oe_n;
         o_strobe_group_oe_n <= next_strobe_oe_n;
         o_area0_burst <= a0_burst;
         o_area0_len <= a0_len;
         o_area5_burst <= a5_burst;
         o_area5_len <= a5_len;
         o_area6_burst <= a6_burst;
         o_area6_len <= a6_len;
      end
   end
endmodule // bus_ctrl_burst_hiz_cfg

/* File: testbench/bus_ctrl_checker_asserts.sv */
// Purpose: port checker for the burst and pin float register block
// Assumes: one clock, async active-low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/1ps
module bus_ctrl_checker (
   input wire i_clk,
   input wire i_nrst,
   input wire i_area0_muxed,
   input wire i_ext_bus_req,
   input wire i_refresh_req,
   input wire i_dma_req,
   input wire i_dma_burst_active,
   input wire i_cpu_req,
   input wire [3:0] o_grant,
   input wire o_bus_released,
   input wire o_addr_group_oe_n,
   input wire o_area0_burst,
   input wire [5:0] o_area0_len
);
   // ****************************
   // arbitration and pin checks
   // ****************************
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_rel;
      i_ext_bus_req && !i_dma_burst_active;
   endsequence
   sequence s_ref;
      !i_ext_bus_req && i_refresh_req && !i_dma_burst_active;
   endsequence
   AST_REL_FIRST: assert property (s_rel |=> o_grant == 4'h1)
      else $error("release not granted first");
   AST_REF_SECOND: assert property (s_ref |=> o_grant == 4'h2)
      else $error("refresh not granted second");
   AST_DMA_THIRD: assert property (!i_ext_bus_req && !i_refresh_req && i_dma_req
      |=> o_grant == 4'h4)
      else $error("dma not granted third");
   AST_CPU_LAST: assert property (i_cpu_req && !i_ext_bus_req && !i_refresh_req
      && !i_dma_req |=> o_grant == 4'h8)
      else $error("cpu not granted last");
   AST_ONE_GRANT: assert property ($onehot0(o_grant))
      else $error("more than one grant");
   AST_REL_FLAG: assert property (o_bus_released == (o_grant == 4'h1))
      else $error("released flag disagrees with grant");
   AST_ADDR_REL: assert property (o_bus_released [*2] |-> o_addr_group_oe_n)
      else $error("address group driven while released");
   AST_PLAIN_LEN: assert property (!o_area0_burst |-> o_area0_len == 6'h01)
      else $error("plain access length not one");
   AST_BURST_LEN: assert property (o_area0_burst
      |-> o_area0_len inside {6'h04, 6'h08, 6'h10, 6'h20})
      else $error("burst length not a legal count");
   AST_MUX_IGN: assert property (i_area0_muxed [*3] |-> !o_area0_burst)
      else $error("area 0 burst used while muxed");
   AST_RST_VAL: assert property ($rose(i_nrst) |-> !o_area0_burst
      && o_grant == 4'h0)
      else $error("values after reset wrong");
endmodule // bus_ctrl_checker
bind bus_ctrl_burst_hiz_cfg bus_ctrl_checker u_chk (.i_clk, .i_nrst, .i_area0_muxed,
   .i_ext_bus_req, .i_refresh_req, .i_dma_req, .i_dma_burst_active, .i_cpu_req,
   .o_grant, .o_bus_released, .o_addr_group_oe_n, .o_area0_burst, .o_area0_len);

/* File: testbench/req_model.sv */
// Purpose: far-side requesters and standby source
// Assumes: command bits {standby, ext, refresh, dma, burst, cpu}
// Notes: levels change just after a rising edge
`timescale 1ns/1ps
module req_model (
   input wire i_clk,
   input wire [5:0] i_cmd,
   output reg o_standby,
   output reg o_ext_bus_req,
   output reg o_refresh_req,
   output reg o_dma_req,
   output reg o_dma_burst_active,
   output reg o_cpu_req
);
   initial begin
      {o_standby, o_ext_bus_req, o_refresh_req, o_dma_req, o_dma_burst_active, o_cpu_req} = 6'h0;
   end
   always @(posedge i_clk) begin
      {o_standby, o_ext_bus_req, o_refresh_req, o_dma_req, o_dma_burst_active, o_cpu_req} <= i_cmd;
   end
endmodule // req_model

/* File: testbench/bus_ctrl_burst_hiz_cfg_test.sv */
// Purpose: register, burst, float and arbitration tests
// Assumes: 20 MHz clock, axi4-lite master tasks
// Notes: settle waits cover the standby synchroniser
`timescale 1ns/1ps
module bus_ctrl_burst_hiz_cfg_test;
   reg i_clk = 0, i_nrst = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   reg i_arvalid = 0, i_rready = 0, i_area0_muxed = 0;
   reg [3:0] i_awaddr = 0, i_araddr = 0, i_wstrb = 4'hf;
   reg [31:0] i_wdata = 0, d;
   reg [5:0] cmd = 0;
   reg [1:0] r;
   reg [9:0] e;
   integer failures = 0, compares = 0, a, c, k;
   wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_bus_released;
   wire o_addr_group_oe_n, o_strobe_group_oe_n, o_area0_burst, o_area5_burst, o_area6_burst;
   wire i_standby, i_ext_bus_req, i_refresh_req, i_dma_req, i_dma_burst_active, i_cpu_req;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   wire [3:0] o_grant;
   wire [5:0] o_area0_len, o_area5_len, o_area6_len;
   localparam [99:0] ARB = {10'h1d1, 10'h0d2, 10'h054, 10'h018, 10'h000,
      10'h161, 10'h364, 10'h2e4, 10'h3d1, 10'h338};
   bus_ctrl_burst_hiz_cfg dut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_area0_muxed, .i_standby,
      .i_ext_bus_req, .i_refresh_req, .i_dma_req, .i_dma_burst_active, .i_cpu_req, .o_grant,
      .o_bus_released, .o_addr_group_oe_n, .o_strobe_group_oe_n, .o_area0_burst,
      .o_area0_len, .o_area5_burst, .o_area5_len, .o_area6_burst, .o_area6_len);
   req_model u_req (.i_clk, .i_cmd(cmd), .o_standby(i_standby), .o_ext_bus_req(i_ext_bus_req),
      .o_refresh_req(i_refresh_req), .o_dma_req(i_dma_req),
      .o_dma_burst_active(i_dma_burst_active), .o_cpu_req(i_cpu_req));
   // ****************************
   // tasks
   // ****************************
   task results;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [8*8:1] what, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("Error %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wr(input [3:0] ad, input [31:0] dt);
      integer n;
      reg done;
      begin
         @(posedge i_clk);
         i_awaddr <= ad; i_wdata <= dt; i_awvalid <= 1'h1; i_wvalid <= 1'h1; i_bready <= 1'h1;
         n = 0; done = 0;
         while (!done) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'h0;
            if (i_wvalid && o_wready) i_wvalid <= 1'h0;
            if (o_bvalid) begin r = o_bresp; i_bready <= 1'h0; done = 1; end
            n = n + 1;
            if (n > 40) begin failures = failures + 1; results; end
         end
      end
   endtask
   task rd(input [3:0] ad);
      integer n;
      reg done;
      begin
         @(posedge i_clk);
         i_araddr <= ad; i_arvalid <= 1'h1; i_rready <= 1'h1;
         n = 0; done = 0;
         while (!done) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'h0;
            if (o_rvalid) begin d = o_rdata; r = o_rresp; i_rready <= 1'h0; done = 1; end
            n = n + 1;
            if (n > 40) begin failures = failures + 1; results; end
         end
      end
   endtask
   task wt(input integer m);
      begin
         repeat (m) @(posedge i_clk);
      end
   endtask
   function [6:0] exp_sel(input [2:0] code);
      begin
         case (code)
            3'h1: exp_sel = 7'h44;
            3'h2: exp_sel = 7'h48;
            3'h3: exp_sel = 7'h50;
            3'h4: exp_sel = 7'h60;
            default: exp_sel = 7'h01;
         endcase
      end
   endfunction
   // ****************************
   // main sequence
   // ****************************
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'h1;
      rd(4'h0); chk("reset", 32'h0, d);
      chk("len5", 32'({o_area5_burst, o_area5_len}), 32'h01);
      wr(4'h0, 32'hffffffff); rd(4'h0); chk("mask", 32'h0003ffe1, d);
      wr(4'h8, 32'h1); chk("wresp", 32'(r), 32'h2);
      rd(4'h8); chk("rresp", 32'(r), 32'h2); chk("rdata", d, 32'h0);
      $display("test access done");
      for (a = 0; a < 3; a = a + 1) begin
         for (c = 0; c < 8; c = c + 1) begin
            wr(4'h0, 32'(c) << (a == 0 ? 11 : (a == 1 ? 8 : 5))); wt(3);
            chk("burst", 32'(a == 0 ? {o_area0_burst, o_area0_len} : (a == 1 ?
               {o_area5_burst, o_area5_len} : {o_area6_burst, o_area6_len})),
               32'(exp_sel(c[2:0])));
         end
      end
      $display("test burst done");
      i_area0_muxed <= 1'h1;
      wr(4'h0, 32'h00020940); wt(3);
      chk("mux0", 32'({o_area0_burst, o_area0_len}), 32'h01);
      chk("mux5", 32'({o_area5_burst, o_area5_len}), 32'h01);
      chk("mux6", 32'({o_area6_burst, o_area6_len}), 32'h01);
      wr(4'h0, 32'h00020041); wt(3);
      chk("pcc6", 32'({o_area6_burst, o_area6_len}), 32'h48);
      rd(4'h4); chk("status", d, 32'h1);
      wr(4'h4, 32'hffffffff); chk("wresp4", 32'(r), 32'h0);
      rd(4'h0); chk("keep", d, 32'h00020041);
      i_area0_muxed <= 1'h0;
      $display("test muxed done");
      for (k = 0; k < 4; k = k + 1) begin
         wr(4'h0, 32'(k) << 14); cmd <= 6'h20; wt(8);
         chk("addr_sb", 32'(o_addr_group_oe_n), 32'(k < 2));
         chk("strb_sb", 32'(o_strobe_group_oe_n), 32'(k % 2 == 0));
         cmd <= 6'h10; wt(8);
         chk("addr_rel", 32'(o_addr_group_oe_n), 32'h1);
         chk("rel", 32'(o_bus_released), 32'h1);
         chk("strb_rel", 32'(o_strobe_group_oe_n), 32'(k % 2 == 0));
         cmd <= 6'h0; wt(2);
      end
      $display("test float done");
      for (k = 0; k < 10; k = k + 1) begin
         e = ARB[k*10 +: 10];
         wr(4'h0, {15'h0, e[9], 16'h0}); cmd <= {1'h0, e[8:4]}; wt(3);
         chk("grant", 32'(o_grant), 32'(e[3:0]));
      end
      cmd <= 6'h0;
      $display("test arbitration done");
      results;
   end
endmodule // bus_ctrl_burst_hiz_cfg_test
